// ===== uhcp_pkg.sv
// package of constants and types for the host capability parameter registers
package uhcp_pkg;
    // register offsets and bus widths
    localparam logic [15:0] STRUCT_PARAMS_OFS   = 16'h0004;
    localparam logic [15:0] CAP_PARAMS_OFS      = 16'h0008;
    localparam int          ADDR_W              = 16;
    localparam int          DATA_W              = 32;
    // structural field positions
    localparam int          PORT_COUNT_LSB      = 0;
    localparam int          PORT_POWER_BIT      = 4;
    localparam int          ROUTING_BIT         = 7;
    localparam int          PER_COMP_LSB        = 8;
    localparam int          COMP_COUNT_LSB      = 12;
    localparam int          INDICATOR_BIT       = 16;
    localparam int          DEBUG_PORT_LSB      = 20;
    // capability field positions
    localparam int          FRAME_LIST_BIT      = 1;
    localparam int          PARK_BIT            = 2;
    localparam int          ISO_THRESH_LSB      = 4;
    localparam int          EXT_CAP_LSB         = 8;
    // reset values
    localparam logic [3:0]  PORT_COUNT_RST      = 4'h1;
    localparam logic        PORT_POWER_RST      = 1'b1;
    localparam logic        ROUTING_RST         = 1'b0;
    localparam logic [3:0]  PER_COMP_RST        = 4'h0;
    localparam logic [3:0]  COMP_COUNT_RST      = 4'h0;
    localparam logic        INDICATOR_RST       = 1'b0;
    localparam logic [3:0]  DEBUG_PORT_RST      = 4'h0;
    localparam logic [7:0]  EXT_CAP_RST         = 8'h00;
    localparam logic [3:0]  ISO_THRESH_RST      = 4'h8;
    localparam logic        PARK_RST            = 1'b1;
    localparam logic        FRAME_LIST_RST      = 1'b1;
    // processor access request
    typedef struct packed {
        logic              rdEn;
        logic              wrEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } uhcp_req_t;
endpackage : uhcp_pkg

// ===== uhcp_param_word.sv
// assembly of the two fixed capability words from their fields
`timescale 1ns/1ns
module uhcp_param_word #(
    parameter logic [3:0] PORT_COUNT = uhcp_pkg::PORT_COUNT_RST,
    parameter logic       PORT_POWER = uhcp_pkg::PORT_POWER_RST,
    parameter logic       ROUTING    = uhcp_pkg::ROUTING_RST,
    parameter logic [3:0] PER_COMP   = uhcp_pkg::PER_COMP_RST,
    parameter logic [3:0] COMP_COUNT = uhcp_pkg::COMP_COUNT_RST,
    parameter logic       INDICATOR  = uhcp_pkg::INDICATOR_RST,
    parameter logic [3:0] DEBUG_PORT = uhcp_pkg::DEBUG_PORT_RST,
    parameter logic [7:0] EXT_CAP    = uhcp_pkg::EXT_CAP_RST,
    parameter logic [3:0] ISO_THRESH = uhcp_pkg::ISO_THRESH_RST,
    parameter logic       PARK       = uhcp_pkg::PARK_RST,
    parameter logic       FRAME_LIST = uhcp_pkg::FRAME_LIST_RST
) (
    // assembled words
    output wire logic [uhcp_pkg::DATA_W-1:0] structWord,
    output wire logic [uhcp_pkg::DATA_W-1:0] capWord
);
    import uhcp_pkg::*;

    wire logic [DATA_W-1:0] sFields;
    wire logic [DATA_W-1:0] cFields;

    // structural word, reserved bits stay zero
    assign sFields = (DATA_W'(PORT_COUNT) << PORT_COUNT_LSB)    // [RL1]
                   | (DATA_W'(PORT_POWER) << PORT_POWER_BIT)    // [RL2]
                   | (DATA_W'(ROUTING)    << ROUTING_BIT)       // [RL3]
                   | (DATA_W'(PER_COMP)   << PER_COMP_LSB)      // [RL4]
                   | (DATA_W'(COMP_COUNT) << COMP_COUNT_LSB)    // [RL5]
                   | (DATA_W'(INDICATOR)  << INDICATOR_BIT)     // [RL6]
                   | (DATA_W'(DEBUG_PORT) << DEBUG_PORT_LSB);   // [RL7]
    // capability word, bits 0, 3 and 31..16 stay zero
    assign cFields = (DATA_W'(EXT_CAP)    << EXT_CAP_LSB)       // [RL9]
                   | (DATA_W'(ISO_THRESH) << ISO_THRESH_LSB)    // [RL10]
                   | (DATA_W'(PARK)       << PARK_BIT)          // [RL11]
                   | (DATA_W'(FRAME_LIST) << FRAME_LIST_BIT);   // [RL12]
    assign structWord = sFields;
    assign capWord    = cFields;
endmodule : uhcp_param_word

// ===== uhcp_regs.sv
// read-only structural and capability parameter registers of the host controller
//
// Overview of operation
// RL1 - the low four bits of the structural word report the number of downstream ports.
// RL2 - bit 4 of the structural word shows whether port power control is provided.
// RL3 - bit 7 of the structural word shows the port routing method to companions.
// RL4 - bits 11 to 8 of the structural word give the ports per companion controller.
// RL5 - bits 15 to 12 of the structural word give the number of companion controllers.
// RL6 - bit 16 of the structural word shows whether port indicators are supported.
// RL7 - bits 23 to 20 of the structural word name the debug port.
// RL8 - software writes zero to all reserved bits of both words.
// RL9 - bits 15 to 8 of the capability word hold the extended capability pointer, zero at reset.
// RL10 - bits 7 to 4 of the capability word give the isochronous scheduling threshold.
// RL11 - bit 2 of the capability word set means asynchronous park is supported.
// RL12 - with bit 1 of the capability word clear, software uses a 1024-entry frame list.
// RL13 - with the programmable frame list flag set, the controller honours a smaller size; here the flag is only exported as progFrameList.
// RL14 - both words are read-only, writes are ignored and reads return fixed values.
`timescale 1ns/1ns
module uhcp_regs #(
    parameter logic [3:0] PORT_COUNT = uhcp_pkg::PORT_COUNT_RST,
    parameter logic       PORT_POWER = uhcp_pkg::PORT_POWER_RST,
    parameter logic       ROUTING    = uhcp_pkg::ROUTING_RST,
    parameter logic [3:0] PER_COMP   = uhcp_pkg::PER_COMP_RST,
    parameter logic [3:0] COMP_COUNT = uhcp_pkg::COMP_COUNT_RST,
    parameter logic       INDICATOR  = uhcp_pkg::INDICATOR_RST,
    parameter logic [3:0] DEBUG_PORT = uhcp_pkg::DEBUG_PORT_RST,
    parameter logic [7:0] EXT_CAP    = uhcp_pkg::EXT_CAP_RST,
    parameter logic [3:0] ISO_THRESH = uhcp_pkg::ISO_THRESH_RST,
    parameter logic       PARK       = uhcp_pkg::PARK_RST,
    parameter logic       FRAME_LIST = uhcp_pkg::FRAME_LIST_RST
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // processor access
    input  wire uhcp_pkg::uhcp_req_t         req,
    output logic [uhcp_pkg::DATA_W-1:0]      rdData,
    output logic                             rdValid,
    output logic                             addrHit,
    // fields seen by the rest of the controller
    output logic                             progFrameList,
    output logic [3:0]                       portCount
);
    import uhcp_pkg::*;

    // a debug port number above the port count names no port
    if (DEBUG_PORT > PORT_COUNT) begin : g_bad_debug
        $error("debug port number exceeds port count");
    end
    if (PORT_COUNT == 4'h0) begin : g_bad_count
        $error("port count must be at least one");
    end

    wire logic [DATA_W-1:0] structWord;
    wire logic [DATA_W-1:0] capWord;
    wire logic              hitStruct;
    wire logic              hitCap;
    wire logic [DATA_W-1:0] readMux;

    logic [DATA_W-1:0] rdData_q;
    logic              rdValid_q;
    logic              addrHit_q;
    logic              progFrameList_q;
    logic [3:0]        portCount_q;

    uhcp_param_word #(
        .PORT_COUNT (PORT_COUNT),
        .PORT_POWER (PORT_POWER),
        .ROUTING    (ROUTING),
        .PER_COMP   (PER_COMP),
        .COMP_COUNT (COMP_COUNT),
        .INDICATOR  (INDICATOR),
        .DEBUG_PORT (DEBUG_PORT),
        .EXT_CAP    (EXT_CAP),
        .ISO_THRESH (ISO_THRESH),
        .PARK       (PARK),
        .FRAME_LIST (FRAME_LIST)
    ) u_word (
        .structWord (structWord),
        .capWord    (capWord)
    );

    // address decode; wrData is never stored, so writes change nothing
    assign hitStruct = (req.addr == STRUCT_PARAMS_OFS);
    assign hitCap    = (req.addr == CAP_PARAMS_OFS);
    assign readMux   = hitStruct ? structWord :             // [RL14]
                       hitCap    ? capWord    : '0;         // unmapped reads as zero

    // read data registered so outputs come from flops; reserved bits read zero [RL8]
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData_q  <= '0;
            rdValid_q <= 1'b0;
            addrHit_q <= 1'b0;
        end else begin
            rdValid_q <= req.rdEn;
            addrHit_q <= req.rdEn & (hitStruct | hitCap);
            rdData_q  <= req.rdEn ? readMux : '0;           // [RL14]
        end
    end

    // frame list flag exported for the command register's size field logic
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            progFrameList_q <= FRAME_LIST_RST;
            portCount_q     <= PORT_COUNT_RST;
        end else begin
            progFrameList_q <= capWord[FRAME_LIST_BIT];      // [RL13]
            portCount_q     <= structWord[PORT_COUNT_LSB +: 4]; // [RL1]
        end
    end

    assign rdData        = rdData_q;
    assign rdValid       = rdValid_q;
    assign addrHit       = addrHit_q;
    assign progFrameList = progFrameList_q;
    assign portCount     = portCount_q;
endmodule : uhcp_regs

// ===== uhcp_regs_monitor.sv
// assertion checker for the capability parameter registers
`timescale 1ns/1ns
module uhcp_regs_monitor #(
    parameter logic [3:0] PORT_COUNT = uhcp_pkg::PORT_COUNT_RST,
    parameter logic [7:0] EXT_CAP    = uhcp_pkg::EXT_CAP_RST,
    parameter logic [3:0] ISO_THRESH = uhcp_pkg::ISO_THRESH_RST,
    parameter logic       FRAME_LIST = uhcp_pkg::FRAME_LIST_RST
) (
    // clock and reset
    input wire logic                        sys_clk,
    input wire logic                        rst,
    // processor access
    input wire uhcp_pkg::uhcp_req_t         req,
    input wire logic [uhcp_pkg::DATA_W-1:0] rdData,
    input wire logic                        rdValid,
    input wire logic                        addrHit,
    // exported fields
    input wire logic                        progFrameList,
    input wire logic [3:0]                  portCount
);
    import uhcp_pkg::*;
    // read decode shared by the properties
    wire logic rdS = req.rdEn && req.addr == STRUCT_PARAMS_OFS;
    wire logic rdC = req.rdEn && req.addr == CAP_PARAMS_OFS;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    read_answer_a: assert property (req.rdEn |=> rdValid) else $error("read not answered");
    idle_quiet_a: assert property (!req.rdEn |=> !rdValid && !addrHit && rdData == '0)
        else $error("answer without read");
    struct_ports_a: assert property (rdS |=> addrHit && rdData[3:0] == PORT_COUNT)
        else $error("port count wrong");
    struct_resvd_a: assert property (rdS |=> rdData[31:24] == '0 && rdData[19:17] == '0
        && rdData[6:5] == '0) else $error("structural reserved bits set");
    ext_pointer_a: assert property (rdC |=> addrHit && rdData[15:8] == EXT_CAP)
        else $error("extended pointer wrong");
    iso_thresh_a: assert property (rdC |=> rdData[7:4] == ISO_THRESH && rdData[31:16] == '0)
        else $error("threshold wrong");
    frame_flag_a: assert property (rdC |=> rdData[1] == FRAME_LIST && progFrameList == rdData[1])
        else $error("frame list flag wrong");
    unmapped_read_a: assert property (req.rdEn && !rdS && !rdC |=> !addrHit && rdData == '0)
        else $error("unmapped read answered");
    fixed_fields_a: assert property (rdValid |-> $stable(portCount) && portCount == PORT_COUNT)
        else $error("port count copy moved");
endmodule : uhcp_regs_monitor
bind uhcp_regs uhcp_regs_monitor #(.PORT_COUNT(PORT_COUNT), .EXT_CAP(EXT_CAP),
    .ISO_THRESH(ISO_THRESH), .FRAME_LIST(FRAME_LIST)) mon_i (.sys_clk(sys_clk), .rst(rst),
    .req(req), .rdData(rdData), .rdValid(rdValid), .addrHit(addrHit),
    .progFrameList(progFrameList), .portCount(portCount));

// ===== testbench.sv
// self-checking bench for the capability parameter registers
`timescale 1ns/1ns
module testbench;
    import uhcp_pkg::*;
    // expected words for the field values instantiated below
    localparam logic [31:0] S_EXP = 32'hD << PORT_COUNT_LSB
        | 32'(PORT_POWER_RST) << PORT_POWER_BIT | 32'hA << COMP_COUNT_LSB
        | 32'h1 << INDICATOR_BIT | 32'hC << DEBUG_PORT_LSB;
    localparam logic [31:0] C_EXP = 32'(ISO_THRESH_RST) << ISO_THRESH_LSB
        | 32'(PARK_RST) << PARK_BIT;
    // reserved positions of each word, kept at zero by software
    localparam logic [31:0] S_RSVD = 32'hFF0E0060;
    localparam logic [31:0] C_RSVD = 32'hFFFF0009;
    logic        sys_clk;
    logic        rst;
    uhcp_req_t   req;
    logic [31:0] rdData;
    logic        rdValid;
    logic        addrHit;
    logic        progFrameList;
    logic [3:0]  portCount;
    logic [32:0] noteQ[$];
    logic [32:0] note;
    logic [31:0] seed;
    int          num_errors;
    int          check_count;
    uhcp_regs #(.PORT_COUNT(4'hD), .COMP_COUNT(4'hA), .INDICATOR(1'b1), .DEBUG_PORT(4'hC),
        .FRAME_LIST(1'b0)) uhcp_regs_i (
        .sys_clk(sys_clk), .rst(rst), .req(req), .rdData(rdData), .rdValid(rdValid),
        .addrHit(addrHit), .progFrameList(progFrameList), .portCount(portCount));
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one request per falling edge; a read files its expected answer
    task automatic access(logic rd, logic wr, logic [15:0] a, logic [31:0] d);
        @(negedge sys_clk);
        // software keeps reserved bits at zero on every write
        req = '{rd, wr, a, d & ~(a == STRUCT_PARAMS_OFS ? S_RSVD
            : a == CAP_PARAMS_OFS ? C_RSVD : 32'h0)};
        if (rd) noteQ.push_back(a == STRUCT_PARAMS_OFS ? {1'b1, S_EXP}
            : a == CAP_PARAMS_OFS ? {1'b1, C_EXP} : 33'h0);
    endtask : access
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // answers are taken at the falling edge, where registered outputs have settled
    always @(negedge sys_clk) begin
        if (!rst && rdValid === 1'b1) begin
            note = noteQ.size() > 0 ? noteQ.pop_front() : 33'h1FFFFFFFF;
            chk("rdData", rdData, note[31:0]);
            chk("addrHit", {31'h0, addrHit}, {31'h0, note[32]});
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // a few hundred cycles are needed; twenty thousand ns means a hang
    initial begin
        #20000;
        num_errors++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        seed = 32'h0E1567B3;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        access(1'b1, 1'b0, STRUCT_PARAMS_OFS, 32'h0);
        access(1'b1, 1'b0, CAP_PARAMS_OFS, 32'h0);
        access(1'b1, 1'b1, STRUCT_PARAMS_OFS, 32'hFFFFFFFF);
        chk("portCount", {28'h0, portCount}, 32'hD);
        chk("progFrameList", {31'h0, progFrameList}, 32'h0);
        $display("test fixed words done");
        // random writes must never disturb later reads
        for (int i = 0; i < 200; i++) begin
            seed = xs(seed);
            access(seed[5], seed[6], seed[4] ? {12'h0, seed[3:2], 2'b00} : seed[31:16], seed);
        end
        access(1'b0, 1'b0, 16'h0, 32'h0);
        repeat (3) @(negedge sys_clk);
        $display("test random access done");
        chk("pending", noteQ.size(), 32'h0);
        final_report();
    end
endmodule : testbench
